// ### inc/sli_pkg.sv
package sli_pkg;

   localparam int unsigned SLI_CLK_HZ = 100_000_000;
   localparam int unsigned SLI_CYC_PER_MS = SLI_CLK_HZ / 1000;
   localparam int unsigned SLI_CNT_W = 27;

   // Lamp timing in milliseconds
   localparam int unsigned SLI_FLASH_MS = 20;
   localparam int unsigned SLI_FAST_MS = 100;
   localparam int unsigned SLI_SLOW_MS = 500;
   localparam int unsigned SLI_RUN_MS = 250;

   localparam logic [SLI_CNT_W-1:0] SLI_FLASH_CYC =
      SLI_CNT_W'(SLI_FLASH_MS * SLI_CYC_PER_MS);
   localparam logic [SLI_CNT_W-1:0] SLI_FAST_CYC =
      SLI_CNT_W'(SLI_FAST_MS * SLI_CYC_PER_MS);
   localparam logic [SLI_CNT_W-1:0] SLI_SLOW_CYC =
      SLI_CNT_W'(SLI_SLOW_MS * SLI_CYC_PER_MS);
   localparam logic [SLI_CNT_W-1:0] SLI_RUN_CYC =
      SLI_CNT_W'(SLI_RUN_MS * SLI_CYC_PER_MS);

   // Register map
   localparam int unsigned SLI_AW = 8;
   localparam logic [SLI_AW-1:0] SLI_CTRL_OFS = 8'h00;
   localparam logic [SLI_AW-1:0] SLI_STAT_OFS = 8'h04;
   localparam int unsigned SLI_CTRL_RUN_BIT = 0;
   localparam int unsigned SLI_CTRL_CFGERR_BIT = 1;
   localparam logic [1:0] SLI_CTRL_RST = 2'h0;
   localparam logic [1:0] SLI_RESP_OKAY = 2'h0;
   localparam logic [1:0] SLI_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [SLI_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [SLI_AW-1:0] araddr;
      logic rready;
   } sli_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sli_axi_rsp_t;

   // Bit 0 is power green, bit 5 info yellow
   typedef struct packed {
      logic info_lamp_yel;
      logic info_lamp_grn;
      logic channel_traffic_lamp_red;
      logic channel_traffic_lamp_yel;
      logic power_lamp_yel;
      logic power_lamp_grn;
   } sli_lamps_t;

   typedef enum logic [1:0] {
      RUN_POWER_GRN,
      RUN_POWER_YEL,
      RUN_TRF_YEL,
      RUN_TRF_RED
   } sli_run_t;

endpackage

// ### design/sli_top.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE1 - Power lamp steady green when powered, configured and healthy.
// RULE2 - Before USB configuration: power slow-blinks yellow, channel dark.
// RULE3 - Faults keep the power lamp in a yellow-bearing pattern.
// RULE4 - Error conditions light the red of every traffic lamp together.
// RULE5 - CAN: idle off, yellow flash per message, red per error frame.
// RULE6 - CAN error passive fast-blinks the traffic lamp red.
// RULE7 - CAN overrun lights steady red until bus-off.
// RULE8 - Firmware update fast-blinks all traffic lamps yellow.
// RULE9 - LIN: idle off, yellow flash per activity or message.
// RULE10 - Info lamp green in LIN, yellow when LIN reference present.
// RULE11 - A flash is a brief pulse; repeated flashes look steady.
// RULE12 - Slow and fast blink have equal halves; fast is quicker.
// RULE13 - Waver swaps between the two colours instead of going dark.
// RULE14 - Running lights each colour singly in the fixed order.
// RULE15 - Pattern timing comes from clock counters with parameter periods.
// RULE16 - Traffic priority: update, overrun, passive, error, activity.
module sli_top
   import sli_pkg::*;
#(
   parameter logic [SLI_CNT_W-1:0] FLASH_CYC = SLI_FLASH_CYC,
   parameter logic [SLI_CNT_W-1:0] FAST_CYC = SLI_FAST_CYC,
   parameter logic [SLI_CNT_W-1:0] SLOW_CYC = SLI_SLOW_CYC,
   parameter logic [SLI_CNT_W-1:0] RUN_CYC = SLI_RUN_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire sli_axi_req_t axi_req,
   output sli_axi_rsp_t axi_rsp,
   input wire logic power_good,
   input wire logic usb_configured,
   input wire logic fw_update,
   input wire logic lin_mode,
   input wire logic lin_vref_ok,
   input wire logic bus_activity,
   input wire logic error_frame,
   input wire logic error_passive,
   input wire logic rx_overrun,
   input wire logic bus_off,
   output sli_lamps_t lamps
);

   logic [1:0] ctrl_q;
   logic ovr_q;
   sli_lamps_t lamps_q;
   sli_run_t step_q;
   sli_run_t step_d;
   logic [SLI_CNT_W-1:0] run_cnt_q;
   wire logic [1:0] tmr_ph;
   wire logic [1:0] flash_on;
   wire logic [1:0] flash_ev;
   wire logic [SLI_CNT_W-1:0] tmr_period [2];

   // Bus slave state
   logic aw_got_q;
   logic w_got_q;
   logic [SLI_AW-1:0] waddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   wire logic run_en = ctrl_q[SLI_CTRL_RUN_BIT];
   wire logic cfg_err = ctrl_q[SLI_CTRL_CFGERR_BIT];
   wire logic fast_ph = tmr_ph[0];
   wire logic slow_ph = tmr_ph[1];
   wire logic normal = power_good & usb_configured & ~cfg_err;

   assign tmr_period[0] = FAST_CYC;
   assign tmr_period[1] = SLOW_CYC;
   assign flash_ev[0] = bus_activity;
   assign flash_ev[1] = error_frame & ~lin_mode;

   // Free-running half-period timers; phase toggles on wrap
   genvar g;
   for (g = 0; g < 2; g++) begin : g_tmr
      logic [SLI_CNT_W-1:0] cnt_q;
      logic ph_q;
      wire logic wrap = cnt_q == tmr_period[g] - 1'b1;
      always_ff @(posedge clk) begin // [RULE12] [RULE15]
         if (!resetn) begin
            cnt_q <= '0;
            ph_q <= 1'b0;
         end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            ph_q <= ph_q ^ wrap;
         end
      end
      assign tmr_ph[g] = ph_q;
   end

   // Retriggerable flash stretchers: 0 yellow, 1 red
   for (g = 0; g < 2; g++) begin : g_flash
      logic [SLI_CNT_W-1:0] cnt_q;
      wire logic busy = cnt_q != '0;
      always_ff @(posedge clk) begin // [RULE11] [RULE15]
         if (!resetn) begin
            cnt_q <= '0;
         end else if (flash_ev[g]) begin
            cnt_q <= FLASH_CYC;
         end else if (busy) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
      assign flash_on[g] = busy;
   end

   // Overrun latch; a new overrun beats a same-cycle bus-off
   wire logic ovr_d = (rx_overrun & ~lin_mode) | (ovr_q & ~bus_off);

   always_ff @(posedge clk) begin // [RULE7]
      if (!resetn) begin
         ovr_q <= 1'b0;
      end else begin
         ovr_q <= ovr_d;
      end
   end

   // Running sequence
   wire logic run_wrap = run_cnt_q == RUN_CYC - 1'b1;

   always_comb begin
      unique case (step_q)
         RUN_POWER_GRN: step_d = RUN_POWER_YEL;
         RUN_POWER_YEL: step_d = RUN_TRF_YEL;
         RUN_TRF_YEL: step_d = RUN_TRF_RED;
         RUN_TRF_RED: step_d = RUN_POWER_GRN;
      endcase
   end

   always_ff @(posedge clk) begin // [RULE14]
      if (!resetn || !run_en) begin
         run_cnt_q <= '0;
         step_q <= RUN_POWER_GRN;
      end else begin
         run_cnt_q <= run_wrap ? '0 : run_cnt_q + 1'b1;
         if (run_wrap) begin
            step_q <= step_d;
         end
      end
   end

   // Lamp selection, {green, yellow} and {yellow, red}
   wire logic [1:0] run_power = {step_q == RUN_POWER_GRN,
                                 step_q == RUN_POWER_YEL};
   wire logic [1:0] run_trf = {step_q == RUN_TRF_YEL,
                               step_q == RUN_TRF_RED};

   wire logic [1:0] power_d =
      run_en ? run_power :                     // [RULE14]
      (!power_good || cfg_err) ?
         {~slow_ph, slow_ph} :                 // [RULE3] [RULE13]
      !usb_configured ? {1'b0, slow_ph} :      // [RULE2]
      2'b10;                                   // [RULE1]

   // Fixed traffic priority below the fault and run cases
   wire logic [1:0] trf_d =
      run_en ? run_trf :
      !power_good ? {slow_ph, 1'b0} :          // [RULE3]
      cfg_err ? {slow_ph, ~slow_ph} :          // [RULE4] [RULE13]
      !usb_configured ? 2'b00 :                // [RULE2]
      fw_update ? {fast_ph, 1'b0} :            // [RULE8] [RULE16]
      lin_mode ? {flash_on[0], 1'b0} :         // [RULE9]
      ovr_q ? 2'b01 :                          // [RULE7] [RULE16]
      error_passive ? {1'b0, fast_ph} :        // [RULE6] [RULE16]
      flash_on[1] ? 2'b01 :                    // [RULE5] [RULE16]
      {flash_on[0], 1'b0};                     // [RULE5]

   // Info pair is {yellow, green}, matching the lamp word order
   wire logic [1:0] inf_d = (normal && !run_en) ?
      {lin_mode & lin_vref_ok, lin_mode} : 2'b00; // [RULE10]

   wire sli_lamps_t lamps_d = {inf_d, trf_d[0], trf_d[1],
                               power_d[0], power_d[1]};

   always_ff @(posedge clk) begin
      if (!resetn) begin
         lamps_q <= '0;
      end else begin
         lamps_q <= lamps_d;
      end
   end

   assign lamps = lamps_q;

   // AXI4-Lite slave, one write and one read in flight
   wire logic awready = ~aw_got_q & ~bvalid_q;
   wire logic wready = ~w_got_q & ~bvalid_q;
   wire logic arready = ~rvalid_q;
   wire logic aw_hs = axi_req.awvalid & awready;
   wire logic w_hs = axi_req.wvalid & wready;
   wire logic ar_hs = axi_req.arvalid & arready;
   wire logic do_wr = aw_got_q & w_got_q;
   wire logic wr_ctrl = waddr_q[7:2] == SLI_CTRL_OFS[7:2];
   wire logic wr_stat = waddr_q[7:2] == SLI_STAT_OFS[7:2];
   wire logic rd_ctrl = axi_req.araddr[7:2] == SLI_CTRL_OFS[7:2];
   wire logic rd_stat = axi_req.araddr[7:2] == SLI_STAT_OFS[7:2];
   wire logic [31:0] rd_word =
      rd_ctrl ? {30'h0, ctrl_q} :
      rd_stat ? {23'h0, ovr_q, 2'h0, lamps_q} : 32'h0;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
      end else begin
         aw_got_q <= (aw_got_q | aw_hs) & ~do_wr;
         w_got_q <= (w_got_q | w_hs) & ~do_wr;
         if (aw_hs) begin
            waddr_q <= axi_req.awaddr;
         end
         if (w_hs) begin
            wdata_q <= axi_req.wdata;
            wstrb0_q <= axi_req.wstrb[0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q <= SLI_CTRL_RST;
         bvalid_q <= 1'b0;
         bresp_q <= SLI_RESP_OKAY;
      end else begin
         if (do_wr && wr_ctrl && wstrb0_q) begin
            ctrl_q <= wdata_q[1:0];
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_ctrl || wr_stat) ?
               SLI_RESP_OKAY : SLI_RESP_SLVERR;
         end else if (axi_req.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= SLI_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= (rd_ctrl || rd_stat) ?
            SLI_RESP_OKAY : SLI_RESP_SLVERR;
      end else if (axi_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign axi_rsp = '{awready: awready, wready: wready,
                      bvalid: bvalid_q, bresp: bresp_q,
                      arready: arready, rvalid: rvalid_q,
                      rdata: rdata_q, rresp: rresp_q};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   wire logic healthy = normal & ~run_en;
   wire logic can_top = healthy & ~fw_update & ~lin_mode;

   a_power_steady: assert property ( // [RULE1]
      healthy |=> lamps.power_lamp_grn && !lamps.power_lamp_yel)
      else $error("power lamp not steady green");

   a_unconf_dark: assert property ( // [RULE2]
      power_good && !usb_configured && !cfg_err && !run_en
      |=> !lamps.channel_traffic_lamp_yel
          && !lamps.channel_traffic_lamp_red
          && lamps.power_lamp_yel == $past(slow_ph))
      else $error("unconfigured pattern wrong");

   a_fault_waver: assert property ( // [RULE3]
      !power_good && !run_en
      |=> lamps.power_lamp_grn != lamps.power_lamp_yel
          && lamps.power_lamp_yel == $past(slow_ph))
      else $error("fault waver wrong");

   a_cfg_red: assert property ( // [RULE4]
      power_good && cfg_err && !run_en && !slow_ph
      |=> lamps.channel_traffic_lamp_red)
      else $error("error red missing");

   a_flash_hold: assert property ( // [RULE11]
      bus_activity |=> flash_on[0] [*8])
      else $error("flash too short");

   a_passive_blink: assert property ( // [RULE6]
      can_top && !ovr_q && error_passive
      |=> lamps.channel_traffic_lamp_red == $past(fast_ph)
          && !lamps.channel_traffic_lamp_yel)
      else $error("passive blink wrong");

   a_err_flash: assert property ( // [RULE5]
      can_top && error_frame ##1 can_top && !ovr_q && !error_passive
      |=> lamps.channel_traffic_lamp_red)
      else $error("error frame flash missing");

   a_ovr_hold: assert property ( // [RULE7]
      ovr_q && !bus_off |=> ovr_q)
      else $error("overrun lost");

   a_ovr_red: assert property ( // [RULE7]
      can_top && ovr_q |=> lamps.channel_traffic_lamp_red
      && !lamps.channel_traffic_lamp_yel)
      else $error("overrun not red");

   a_ovr_clear: assert property ( // [RULE7]
      bus_off && !(rx_overrun && !lin_mode) |=> !ovr_q)
      else $error("overrun not cleared by bus-off");

   a_fw_blink: assert property ( // [RULE8]
      healthy && fw_update
      |=> lamps.channel_traffic_lamp_yel == $past(fast_ph)
          && !lamps.channel_traffic_lamp_red)
      else $error("update blink wrong");

   a_lin_info: assert property ( // [RULE10]
      healthy |=> lamps.info_lamp_grn == $past(lin_mode)
      && lamps.info_lamp_yel == $past(lin_mode && lin_vref_ok))
      else $error("info lamp wrong");

   a_lin_no_red: assert property ( // [RULE9]
      healthy && lin_mode |=> !lamps.channel_traffic_lamp_red)
      else $error("red lamp lit in LIN");

   a_slow_equal: assert property ( // [RULE12]
      $changed(slow_ph) |-> $past(g_tmr[1].cnt_q) == SLOW_CYC - 1'b1)
      else $error("slow half period wrong");

   a_fast_equal: assert property ( // [RULE12]
      $changed(fast_ph) |-> $past(g_tmr[0].cnt_q) == FAST_CYC - 1'b1)
      else $error("fast half period wrong");

   a_run_onehot: assert property ( // [RULE14]
      run_en && $past(run_en) |=> $onehot(lamps[3:0]))
      else $error("running not one at a time");

   c_can_flash: cover property (can_top && bus_activity ##2
      lamps.channel_traffic_lamp_yel);
   c_ovr_clear: cover property (ovr_q ##1 bus_off ##1 !ovr_q);
   c_run_wrap: cover property (run_en && step_q == RUN_TRF_RED
      && run_wrap);
   c_axi_write: cover property (do_wr && wr_ctrl);
   c_lin_vref: cover property (healthy && lin_mode && lin_vref_ok);

endmodule

// ### tb/sli_chan_model.sv
`timescale 1ns/1ps
// Channel controller status source; events leave just after a clock edge
module sli_chan_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [4:0] ev,
   output logic bus_activity,
   output logic error_frame,
   output logic rx_overrun,
   output logic error_passive,
   output logic bus_off
);
   logic [4:0] st_q;
   assign {bus_off, error_passive, rx_overrun, error_frame, bus_activity} =
      st_q;
   always_ff @(posedge clk) begin
      st_q <= resetn ? ev : 5'h00;
   end
endmodule

// ### tb/sli_top_test.sv
`timescale 1ns/1ps
module sli_top_test;
   import sli_pkg::*;
   localparam int FL = 32'h8;
   localparam int FA = 32'h4;
   localparam int SL = 32'hA;
   localparam int RU = 32'h6;
   logic clk, resetn, pg, cfg, fw, lin, vref;
   logic act, errf, ovr, pas, boff;
   logic [4:0] ev;
   logic [31:0] d;
   logic [3:0] strb;
   sli_axi_req_t req;
   sli_axi_rsp_t rsp;
   sli_lamps_t lamps;
   int num_errors, check_count;
   sli_chan_model u_sli_chan_model (.clk(clk), .resetn(resetn), .ev(ev),
      .bus_activity(act), .error_frame(errf), .rx_overrun(ovr),
      .error_passive(pas), .bus_off(boff));
   sli_top #(.FLASH_CYC(SLI_CNT_W'(FL)), .FAST_CYC(SLI_CNT_W'(FA)),
      .SLOW_CYC(SLI_CNT_W'(SL)), .RUN_CYC(SLI_CNT_W'(RU))) u_sli_top (
      .clk(clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
      .power_good(pg), .usb_configured(cfg), .fw_update(fw),
      .lin_mode(lin), .lin_vref_ok(vref), .bus_activity(act),
      .error_frame(errf), .error_passive(pas), .rx_overrun(ovr),
      .bus_off(boff), .lamps(lamps));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bit order of ev: bus_off, passive, overrun, error frame, activity
   task automatic fire(logic [4:0] e);
      ev <= ev | e;
      cyc(1);
      ev <= ev & ~e;
   endtask
   // Counts one full phase of a blinking lamp bit
   task automatic half(int i, int exp, string nm);
      logic v;
      int n;
      for (int k = 0; k < 2; k++) begin
         v = lamps[i];
         n = 0;
         while (lamps[i] === v && n < 200) begin
            cyc(1);
            n++;
         end
      end
      chk(nm, 32'(n), 32'(exp));
   endtask
   task automatic lit(int i, string nm);
      int n;
      n = 0;
      while (lamps[i] !== 1'b1 && n < 6) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (lamps[i] === 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk(nm, 32'(n), 32'(FL));
   endtask
   // Handshakes are judged at the rising edge, before the slave's flops move
   task automatic axw(logic [7:0] a, logic [31:0] wd, logic [1:0] er);
      int n;
      n = 0;
      req.awaddr <= a;
      req.wdata <= wd;
      req.wstrb <= strb;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         n++;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      chk("bresp", 32'(rsp.bresp), 32'(er));
      chk("b_wait", 32'(n), 32'h3);
      #1;
   endtask
   task automatic axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
      int n;
      n = 0;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         n++;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
      chk("rdata", rsp.rdata, ed);
      chk("rresp", 32'(rsp.rresp), 32'(er));
      chk("r_wait", 32'(n), 32'h2);
      #1;
   endtask
   task automatic t_start();
      cfg <= 1'b0;
      cyc(2);
      chk("unconf_trf", 32'(lamps[3:2]), 32'h0);
      chk("unconf_grn", 32'(lamps[0]), 32'h0);
      half(1, SL, "unconf_yel");
      cfg <= 1'b1;
      pg <= 1'b0;
      cyc(2);
      for (int k = 0; k < 4; k++) begin
         chk("pg_waver", 32'(lamps[0] ^ lamps[1]), 32'h1);
         cyc(3);
      end
      half(2, SL, "power_bad_trf");
      pg <= 1'b1;
      cyc(3);
      chk("idle", 32'(lamps), 32'h01);
   endtask
   task automatic t_can();
      fire(5'h01);
      lit(2, "act_flash");
      for (int k = 0; k < 12; k++) begin
         if (k % 4 == 0) fire(5'h01);
         else cyc(1);
         if (k > 2) chk("flash_run", 32'(lamps[2]), 32'h1);
      end
      cyc(FL + 3);
      fire(5'h02);
      lit(3, "err_flash");
      ev <= 5'h08;
      cyc(3);
      half(3, FA, "passive");
      fire(5'h04);
      for (int k = 0; k < 10; k++) begin
         if (k > 1) chk("ovr_red", 32'(lamps[3:2]), 32'h2);
         cyc(1);
      end
      axr(SLI_STAT_OFS, 32'h109, SLI_RESP_OKAY);
      fw <= 1'b1;
      cyc(2);
      chk("fw_red", 32'(lamps[3]), 32'h0);
      half(2, FA, "fw_yel");
      fw <= 1'b0;
      ev <= 5'h00;
      cyc(3);
      chk("ovr_held", 32'(lamps[3]), 32'h1);
      fire(5'h10);
      cyc(3);
      chk("busoff", 32'(lamps[3:2]), 32'h0);
   endtask
   task automatic t_lin();
      lin <= 1'b1;
      cyc(2);
      chk("info_lin", 32'(lamps[5:4]), 32'h1);
      vref <= 1'b1;
      cyc(2);
      chk("info_vref", 32'(lamps[5:4]), 32'h3);
      fire(5'h02);
      for (int k = 0; k < 5; k++) begin
         cyc(1);
         chk("lin_err", 32'(lamps[3:2]), 32'h0);
      end
      fire(5'h01);
      lit(2, "lin_flash");
      fw <= 1'b1;
      cyc(2);
      half(2, FA, "lin_fw");
      fw <= 1'b0;
      lin <= 1'b0;
      vref <= 1'b0;
      cyc(2);
   endtask
   task automatic t_regs();
      axr(SLI_CTRL_OFS, 32'h0, SLI_RESP_OKAY);
      axr(8'h10, 32'h0, SLI_RESP_SLVERR);
      axw(8'h10, 32'h3, SLI_RESP_SLVERR);
      // A write with byte 0 disabled must leave the control word alone
      strb = 4'h0;
      axw(SLI_CTRL_OFS, 32'h3, SLI_RESP_OKAY);
      strb = 4'hF;
      axw(SLI_STAT_OFS, 32'hFF, SLI_RESP_OKAY);
      axr(SLI_CTRL_OFS, 32'h0, SLI_RESP_OKAY);
      axw(SLI_CTRL_OFS, 32'h2, SLI_RESP_OKAY);
      cyc(2);
      chk("cfg_trf", 32'(lamps[2] ^ lamps[3]), 32'h1);
      chk("cfg_power", 32'(lamps[0] ^ lamps[1]), 32'h1);
      half(3, SL, "cfg_red");
      axr(SLI_CTRL_OFS, 32'h2, SLI_RESP_OKAY);
      axw(SLI_CTRL_OFS, 32'h1, SLI_RESP_OKAY);
      d = 0;
      while (lamps[3:0] !== 4'h2 && d < 40) begin
         cyc(1);
         d++;
      end
      cyc(RU / 2);
      for (int k = 1; k < 6; k++) begin
         chk("run", 32'(lamps[3:0]), 32'(1 << (k % 4)));
         chk("run_info", 32'(lamps[5:4]), 32'h0);
         cyc(RU);
      end
      axw(SLI_CTRL_OFS, 32'h0, SLI_RESP_OKAY);
      cyc(3);
      chk("run_off", 32'(lamps), 32'h01);
   endtask
   task automatic finish_test();
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   initial begin
      req = '0;
      strb = 4'hF;
      ev = 5'h00;
      {pg, cfg, fw, lin, vref} = 5'h18;
      resetn = 1'b0;
      num_errors = 0;
      check_count = 0;
      cyc(5);
      resetn <= 1'b1;
      cyc(1);
      t_start();
      t_can();
      t_lin();
      t_regs();
      finish_test();
   end
endmodule
